/* rtl/asr_receiver.sv */
// Purpose: Asynchronous serial receiver with 9-bit address detect, reached over APB.
// Assumes: Serial input is asynchronous to core_clk; sleep_mode comes from core_clk logic.
// Notes: Transmitter bits of the shared registers are stored only; no transmitter exists here.
// How it works
// - Sixteen-times oversampling recovery feeds bit-rate shifter.
// - Receive only while continuous receive enable set.
// - After stop bit, move word, set full flag.
// - Interrupt equals enable bit and buffer-full flag.
// - Full flag read-only, clears when buffer empty.
// - Receive buffer is a two-entry FIFO.
// - Full FIFO at stop bit sets overrun, drops.
// - Overrun clears only by toggling continuous enable.
// - Overrun blocks every transfer into the FIFO.
// - Stop bit sampled zero sets framing error.
// - Framing and ninth bit queued per entry.
// - Nine-bit enable accepts nine data bits.
// - Address detect enable gates nine-bit reception.
// - Receive status/control resets to zero; transmit status/control resets to 02h.
// - Start, eight/nine LSB-first data, one stop.
// - Baud clock is x16 or x64 bit rate.
// - Reception halts during sleep.
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module asr_receiver (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic sys_rst,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [asr_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial line and system.
   input wire logic rx_pin,
   input wire logic sleep_mode,
   // Interrupt request toward the core.
   output logic receive_irq
);
   // Register decode.
   logic setup_phase;
   logic access_phase;
   logic [9:0] word_idx;
   logic aligned;
   logic hit_flags;
   logic hit_status;
   logic hit_buffer;
   logic hit_enables;
   logic hit_txstat;
   logic hit_divisor;
   logic mapped;
   logic wr_en;
   logic rd_buffer_done;

   // Software registers.
   logic [7:0] receive_status_control_ctl_ff;
   logic [7:0] pie_ff;
   logic [7:0] transmit_status_control_ff;
   logic [7:0] baud_divisor_ff;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic pop_armed_ff;

   // Control bits.
   logic serial_port_enable;
   logic nine_bit_receive_enable;
   logic continuous_receive_enable;
   logic address_detect_enable;
   logic clocked_mode;
   logic high_baud_select;
   logic rx_run;

   // Pin synchroniser and filtered level.
   logic rx_s1_ff;
   logic rx_s2_ff;
   logic rx_s3_ff;
   logic rx_lvl_ff;
   logic rx_prev_ff;
   logic rx_fell;

   // Frame engine.
   asr_pkg::asr_state_e state_ff;
   asr_pkg::asr_state_e nxt_state;
   logic [3:0] tick_cnt_ff;
   logic [3:0] nxt_tick_cnt;
   logic [3:0] bit_cnt_ff;
   logic [3:0] nxt_bit_cnt;
   logic [8:0] receive_shift_register_ff;
   logic [8:0] nxt_shift;
   logic sample_tick;
   logic cell_end;
   logic word_done;
   logic [3:0] frame_bits;

   // Word disposition and status.
   logic [7:0] word_data;
   logic word_ninth;
   logic word_framing_error;
   logic word_wanted;
   logic overrun_error_ff;
   logic nxt_overrun;
   logic receive_buffer_full_flag_ff;
   logic receive_irq_ff;
   logic fifo_push;
   logic fifo_space;
   logic fifo_has_data;
   logic fifo_pop;
   logic [asr_pkg::ENTRY_W-1:0] fifo_head;
   logic [7:0] receive_buffer;
   logic framing_error;
   logic received_ninth_bit;
   logic [7:0] receive_status_control_view;
   logic [7:0] flags_view;
   logic [7:0] transmit_status_control_view;

   function automatic logic [31:0] byte_word(input logic [7:0] b);
      byte_word = {24'h000000, b};
   endfunction

   // APB decode.
   assign setup_phase = psel && !penable;
   assign access_phase = psel && penable;
   assign word_idx = paddr[asr_pkg::ADDR_W-1:2];
   assign aligned = (paddr[1:0] == 2'b00);
   assign hit_flags = aligned && (word_idx == asr_pkg::IDX_PERIPHERAL_IRQ_FLAGS);
   assign hit_status = aligned && (word_idx == asr_pkg::IDX_RECEIVE_STATUS_CONTROL);
   assign hit_buffer = aligned && (word_idx == asr_pkg::IDX_RECEIVE_BUFFER);
   assign hit_enables = aligned && (word_idx == asr_pkg::IDX_PERIPHERAL_IRQ_ENABLES);
   assign hit_txstat = aligned && (word_idx == asr_pkg::IDX_TRANSMIT_STATUS_CONTROL);
   assign hit_divisor = aligned && (word_idx == asr_pkg::IDX_BAUD_DIVISOR);
   assign mapped = hit_flags || hit_status || hit_buffer || hit_enables || hit_txstat || hit_divisor;
   assign pready = 1'b1;
   assign pslverr = access_phase && !mapped;
   assign wr_en = access_phase && pwrite && mapped;
   assign prdata = prdata_ff;

   // A read of the buffer pops only the word that was captured in the setup cycle.
   assign rd_buffer_done = access_phase && !pwrite && hit_buffer && pop_armed_ff;

   // Control fields.
   assign serial_port_enable = receive_status_control_ctl_ff[asr_pkg::BIT_SERIAL_PORT_ENABLE];
   assign nine_bit_receive_enable = receive_status_control_ctl_ff[asr_pkg::BIT_NINE_BIT_ENABLE];
   assign continuous_receive_enable = receive_status_control_ctl_ff[asr_pkg::BIT_CONT_RX_ENABLE];
   assign address_detect_enable = receive_status_control_ctl_ff[asr_pkg::BIT_ADDRESS_DETECT];
   assign clocked_mode = transmit_status_control_ff[asr_pkg::BIT_CLOCKED_MODE];
   assign high_baud_select = transmit_status_control_ff[asr_pkg::BIT_HIGH_BAUD];

   // Reception needs the port on, asynchronous mode, continuous enable and no sleep.
   assign rx_run = serial_port_enable && !clocked_mode && continuous_receive_enable && !sleep_mode;

   // Head of queue supplies the data and its own status bits.
   assign receive_buffer = fifo_has_data ? fifo_head[7:0] : asr_pkg::RST_BYTE;
   assign received_ninth_bit = fifo_has_data && fifo_head[8];
   assign framing_error = fifo_has_data && fifo_head[9];

   assign receive_status_control_view = (receive_status_control_ctl_ff & asr_pkg::RECEIVE_STATUS_CONTROL_WR_MASK)
                     | (8'(framing_error) << asr_pkg::BIT_FRAMING_ERROR)
                     | (8'(overrun_error_ff) << asr_pkg::BIT_OVERRUN_ERROR)
                     | (8'(received_ninth_bit) << asr_pkg::BIT_NINTH_BIT);
   assign flags_view = 8'(receive_buffer_full_flag_ff) << asr_pkg::BIT_BUFFER_FULL;
   // The shifter-empty bit belongs to the absent transmitter and reads as idle.
   assign transmit_status_control_view = (transmit_status_control_ff & asr_pkg::TRANSMIT_STATUS_CONTROL_WR_MASK)
                     | (8'h01 << asr_pkg::BIT_SHIFTER_EMPTY);

   assign nxt_prdata = !setup_phase || pwrite ? prdata_ff :
                       hit_flags ? byte_word(flags_view) :
                       hit_status ? byte_word(receive_status_control_view) :
                       hit_buffer ? byte_word(receive_buffer) :
                       hit_enables ? byte_word(pie_ff) :
                       hit_txstat ? byte_word(transmit_status_control_view) :
                       hit_divisor ? byte_word(baud_divisor_ff) : 32'h00000000;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata_ff <= 32'h00000000;
         pop_armed_ff <= 1'b0;
      end else begin
         prdata_ff <= nxt_prdata;
         if (setup_phase) begin
            pop_armed_ff <= fifo_has_data;
         end
      end
   end

   // Register writes; status bits and the buffer-full flag ignore software.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         receive_status_control_ctl_ff <= asr_pkg::RST_BYTE;
         pie_ff <= asr_pkg::RST_BYTE;
         transmit_status_control_ff <= asr_pkg::RST_TRANSMIT_STATUS;
         baud_divisor_ff <= asr_pkg::RST_BYTE;
      end else if (wr_en) begin
         if (hit_status) begin
            receive_status_control_ctl_ff <= pwdata[7:0] & asr_pkg::RECEIVE_STATUS_CONTROL_WR_MASK;
         end
         if (hit_enables) begin
            pie_ff <= pwdata[7:0];
         end
         if (hit_txstat) begin
            transmit_status_control_ff <= pwdata[7:0] & asr_pkg::TRANSMIT_STATUS_CONTROL_WR_MASK;
         end
         if (hit_divisor) begin
            baud_divisor_ff <= pwdata[7:0];
         end
      end
   end

   // Three flops on the pin; the level moves only when the last two agree.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_s1_ff <= 1'b1;
         rx_s2_ff <= 1'b1;
         rx_s3_ff <= 1'b1;
         rx_lvl_ff <= 1'b1;
         rx_prev_ff <= 1'b1;
      end else begin
         rx_s1_ff <= rx_pin;
         rx_s2_ff <= rx_s1_ff;
         rx_s3_ff <= rx_s2_ff;
         if (rx_s2_ff == rx_s3_ff) begin
            rx_lvl_ff <= rx_s3_ff;
         end
         rx_prev_ff <= rx_lvl_ff;
      end
   end

   assign rx_fell = rx_prev_ff && !rx_lvl_ff;

   asr_baud_gen u_baud (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .run(rx_run),
      .high_baud_select(high_baud_select),
      .baud_divisor(baud_divisor_ff),
      .sample_tick(sample_tick)
   );

   // Frame engine: sixteen ticks per cell, the shifter advancing once per cell.
   assign frame_bits = nine_bit_receive_enable ? asr_pkg::BITS_NINE : asr_pkg::BITS_EIGHT;
   assign cell_end = sample_tick && (tick_cnt_ff == asr_pkg::LAST_SAMPLE);
   assign word_done = (state_ff == asr_pkg::ST_STOP) && cell_end;

   always_comb begin
      nxt_state = state_ff;
      nxt_tick_cnt = tick_cnt_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_shift = receive_shift_register_ff;
      case (state_ff)
         asr_pkg::ST_IDLE: begin
            nxt_tick_cnt = 4'h0;
            if (rx_fell) begin
               nxt_state = asr_pkg::ST_START;
            end
         end
         asr_pkg::ST_START: begin
            if (sample_tick) begin
               nxt_tick_cnt = tick_cnt_ff + 4'h1;
               // A start bit that is high again at mid-cell was a glitch.
               if (tick_cnt_ff == asr_pkg::MID_SAMPLE) begin
                  nxt_tick_cnt = 4'h0;
                  nxt_bit_cnt = 4'h0;
                  nxt_state = rx_lvl_ff ? asr_pkg::ST_IDLE : asr_pkg::ST_DATA;
               end
            end
         end
         asr_pkg::ST_DATA: begin
            if (sample_tick) begin
               nxt_tick_cnt = tick_cnt_ff + 4'h1;
            end
            if (cell_end) begin
               nxt_shift = {rx_lvl_ff, receive_shift_register_ff[8:1]};
               nxt_bit_cnt = bit_cnt_ff + 4'h1;
               if (bit_cnt_ff + 4'h1 == frame_bits) begin
                  nxt_state = asr_pkg::ST_STOP;
               end
            end
         end
         asr_pkg::ST_STOP: begin
            if (sample_tick) begin
               nxt_tick_cnt = tick_cnt_ff + 4'h1;
            end
            if (cell_end) begin
               nxt_state = asr_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_state = asr_pkg::ST_IDLE;
         end
      endcase
      // Dropping enable, entering sleep or switching mode resets the receive logic.
      if (!rx_run) begin
         nxt_state = asr_pkg::ST_IDLE;
         nxt_tick_cnt = 4'h0;
         nxt_bit_cnt = 4'h0;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= asr_pkg::ST_IDLE;
         tick_cnt_ff <= 4'h0;
         bit_cnt_ff <= 4'h0;
         receive_shift_register_ff <= 9'h000;
      end else begin
         state_ff <= nxt_state;
         tick_cnt_ff <= nxt_tick_cnt;
         bit_cnt_ff <= nxt_bit_cnt;
         receive_shift_register_ff <= nxt_shift;
      end
   end

   // In 8-bit frames the word sits one place high in the 9-bit shifter.
   assign word_data = nine_bit_receive_enable ? receive_shift_register_ff[7:0]
                                              : receive_shift_register_ff[8:1];
   assign word_ninth = nine_bit_receive_enable && receive_shift_register_ff[8];
   assign word_framing_error = !rx_lvl_ff;
   // Address words alone pass while detection is on in 9-bit mode.
   assign word_wanted = !(nine_bit_receive_enable && address_detect_enable) || word_ninth;
   assign fifo_push = word_done && word_wanted && !overrun_error_ff && fifo_space;

   // Overrun is set by a word that finds no room; only clearing continuous enable clears it.
   assign nxt_overrun = !continuous_receive_enable ? 1'b0 :
                        (word_done && word_wanted && !fifo_space) ? 1'b1 :
                        overrun_error_ff;

   assign fifo_pop = rd_buffer_done;

   asr_rx_fifo #(
      .WIDTH(asr_pkg::ENTRY_W),
      .DEPTH(asr_pkg::FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .push_valid(fifo_push),
      .push_ready(fifo_space),
      .push_data({word_framing_error, word_ninth, word_data}),
      .pop_valid(fifo_has_data),
      .pop_ready(fifo_pop),
      .head_data(fifo_head)
   );

   // The flag follows FIFO occupancy one cycle late, so a push beside a pop keeps it set.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         overrun_error_ff <= 1'b0;
         receive_buffer_full_flag_ff <= 1'b0;
         receive_irq_ff <= 1'b0;
      end else begin
         overrun_error_ff <= nxt_overrun;
         receive_buffer_full_flag_ff <= fifo_has_data;
         receive_irq_ff <= fifo_has_data && pie_ff[asr_pkg::BIT_RX_IRQ_ENABLE];
      end
   end

   assign receive_irq = receive_irq_ff;
endmodule
`default_nettype wire

/* rtl/asr_pkg.sv */
// Purpose: Shared constants for the asynchronous serial receiver with address detect.
// Assumes: Registers sit one per 32-bit APB word at byte address four times their index.
// Notes: Bit positions are those of the 8-bit registers; upper data bits read as zero.
package asr_pkg;
   // Register indices and the APB address width.
   localparam logic [9:0] IDX_PERIPHERAL_IRQ_FLAGS = 10'h00C;
   localparam logic [9:0] IDX_RECEIVE_STATUS_CONTROL = 10'h018;
   localparam logic [9:0] IDX_RECEIVE_BUFFER = 10'h01A;
   localparam logic [9:0] IDX_PERIPHERAL_IRQ_ENABLES = 10'h08C;
   localparam logic [9:0] IDX_TRANSMIT_STATUS_CONTROL = 10'h098;
   localparam logic [9:0] IDX_BAUD_DIVISOR = 10'h099;
   localparam int ADDR_W = 12;

   // Field positions.
   localparam int BIT_BUFFER_FULL = 5;
   localparam int BIT_RX_IRQ_ENABLE = 5;
   localparam int BIT_SERIAL_PORT_ENABLE = 7;
   localparam int BIT_NINE_BIT_ENABLE = 6;
   localparam int BIT_SINGLE_RX_ENABLE = 5;
   localparam int BIT_CONT_RX_ENABLE = 4;
   localparam int BIT_ADDRESS_DETECT = 3;
   localparam int BIT_FRAMING_ERROR = 2;
   localparam int BIT_OVERRUN_ERROR = 1;
   localparam int BIT_NINTH_BIT = 0;
   localparam int BIT_CLOCKED_MODE = 4;
   localparam int BIT_HIGH_BAUD = 2;
   localparam int BIT_SHIFTER_EMPTY = 1;

   // Reset values and writable masks.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_TRANSMIT_STATUS = 8'h02;
   localparam logic [7:0] RECEIVE_STATUS_CONTROL_WR_MASK = 8'hF8;
   localparam logic [7:0] TRANSMIT_STATUS_CONTROL_WR_MASK = 8'hF5;

   // Sampling geometry.
   localparam int SAMPLES_PER_BIT = 16;
   localparam logic [3:0] LAST_SAMPLE = 4'hF;
   localparam logic [3:0] MID_SAMPLE = 4'h7;
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;
   localparam logic [1:0] LOW_SPEED_PRESCALE_MAX = 2'h3;
   localparam int FIFO_DEPTH = 2;
   localparam int ENTRY_W = 10;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_START = 2'b01,
      ST_DATA = 2'b10,
      ST_STOP = 2'b11
   } asr_state_e;
endpackage

/* rtl/asr_baud_gen.sv */
// Purpose: Produces the sixteen-times bit-rate sample tick from the baud divisor.
// Assumes: Low speed divides the core clock by 64 per bit per divisor step, high speed by 16.
// Notes: The prescaler is held at zero and the divisor counter at baud_divisor while the receiver is stopped so the first tick is deterministic.
`timescale 1ns/100ps
`default_nettype none
module asr_baud_gen (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic sys_rst,
   // Control.
   input wire logic run,
   input wire logic high_baud_select,
   input wire logic [7:0] baud_divisor,
   // Output.
   output logic sample_tick
);
   logic [1:0] pre_ff;
   logic [1:0] nxt_pre;
   logic [7:0] div_ff;
   logic [7:0] nxt_div;
   logic pre_wrap;
   logic div_wrap;

   assign pre_wrap = (pre_ff == 2'h0);
   assign div_wrap = (div_ff == 8'h00);
   assign sample_tick = run && pre_wrap && div_wrap;
   assign nxt_pre = !run ? 2'h0 :
                    pre_wrap ? (high_baud_select ? 2'h0 : asr_pkg::LOW_SPEED_PRESCALE_MAX) :
                    pre_ff - 2'h1;
   assign nxt_div = !run ? baud_divisor :
                    !pre_wrap ? div_ff :
                    div_wrap ? baud_divisor : div_ff - 8'h01;

   // The x64 or x16 bit clock is the divisor chain with or without the prescaler.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pre_ff <= 2'h0;
         div_ff <= 8'h00;
      end else begin
         pre_ff <= nxt_pre;
         div_ff <= nxt_div;
      end
   end
endmodule
`default_nettype wire

/* rtl/asr_rx_fifo.sv */
// Purpose: Small receive FIFO holding data with its per-word status bits.
// Assumes: Push and pop may occur in the same cycle; a push into a full FIFO is refused.
// Notes: The head word is presented combinationally from the storage flops.
`timescale 1ns/100ps
`default_nettype none
module asr_rx_fifo #(
   parameter int WIDTH = asr_pkg::ENTRY_W,
   parameter int DEPTH = asr_pkg::FIFO_DEPTH
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic sys_rst,
   // Fill side.
   input wire logic push_valid,
   output logic push_ready,
   input wire logic [WIDTH-1:0] push_data,
   // Drain side.
   output logic pop_valid,
   input wire logic pop_ready,
   output logic [WIDTH-1:0] head_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0] rd_ff;
   logic [PW-1:0] wr_ff;
   logic [PW:0] cnt_ff;
   logic do_push;
   logic do_pop;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   assign push_ready = (cnt_ff != (PW+1)'(DEPTH));
   assign pop_valid = (cnt_ff != '0);
   assign do_push = push_valid && push_ready;
   assign do_pop = pop_ready && pop_valid;
   assign head_data = mem_ff[rd_ff];

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_ff <= '0;
         wr_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (do_push) begin
            wr_ff <= ptr_inc(wr_ff);
         end
         if (do_pop) begin
            rd_ff <= ptr_inc(rd_ff);
         end
         cnt_ff <= cnt_ff + (PW+1)'(do_push) - (PW+1)'(do_pop);
      end
   end

   always_ff @(posedge core_clk) begin
      if (do_push) begin
         mem_ff[wr_ff] <= push_data;
      end
   end
endmodule
`default_nettype wire

/* verif/asr_receiver_monitor.sv */
// Purpose: Port-level checks of the serial receiver.
// Assumes: Sees only the top ports; flags and FIFO state are internal.
// Notes: Interrupt timing is judged against APB accesses because pops are only visible there.
`timescale 1ns/100ps
`default_nettype none
module asr_receiver_monitor (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic sys_rst,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [asr_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Interrupt.
   input wire logic receive_irq
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   wire logic acc = psel && penable;
   wire logic mapped = paddr inside {12'h030, 12'h060, 12'h068, 12'h230, 12'h260, 12'h264};
   ready_in_access_a: assert property (acc |-> pready)
      else $error("pready low in access");
   err_only_access_a: assert property (pslverr |-> acc)
      else $error("pslverr outside access");
   err_on_unmapped_a: assert property (acc && !mapped |-> pslverr)
      else $error("no pslverr on unmapped");
   no_err_mapped_a: assert property (acc && mapped |-> !pslverr)
      else $error("pslverr on mapped");
   bad_read_zero_a: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   upper_bits_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
      else $error("read upper bits set");
   rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("prdata moved outside setup");
   irq_hold_a: assert property (receive_irq && !psel && !$past(psel) |=> receive_irq)
      else $error("irq dropped without access");
   irq_fall_a: assert property ($fell(receive_irq) |->
      ($past(acc, 1) || $past(acc, 2) || $past(acc, 3)))
      else $error("irq fell without a read");
endmodule
bind asr_receiver asr_receiver_monitor u_mon (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .receive_irq(receive_irq));
`default_nettype wire

/* verif/asr_serial_tx_model.sv */
// Purpose: Remote asynchronous transmitter driving the receive line.
// Assumes: Caller gives the bit time; the line idles high.
// Notes: A full idle bit follows each stop so a bad stop still leaves a clean start edge.
`timescale 1ns/100ps
`default_nettype none
module asr_serial_tx_model (
   // Serial line.
   output logic rx_pin
);
   initial rx_pin = 1'b1;
   task automatic send(input logic [8:0] d, input logic nine, input logic stop, input realtime bt);
      int n;
      n = nine ? 9 : 8;
      #3;
      rx_pin = 1'b0;
      #(bt);
      for (int i = 0; i < n; i++) begin
         rx_pin = d[i];
         #(bt);
      end
      rx_pin = stop;
      #(bt);
      rx_pin = 1'b1;
      #(bt);
   endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// Purpose: Self-checking bench for the serial receiver.
// Assumes: High-speed divisor 0 gives 16 clocks per bit.
// Notes: Waits after frames are fixed because a dropped word gives no event to wait on.
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic sleep_mode = 1'b0;
   wire logic rx_pin;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic receive_irq;
   int n_mismatch = 0;
   int n_checks = 0;
   localparam realtime BT = 128.0;
   asr_receiver uut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_pin(rx_pin), .sleep_mode(sleep_mode), .receive_irq(receive_irq));
   asr_serial_tx_model u_tx (.rx_pin(rx_pin));
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      int k;
      k = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1 && k < 16) begin
         @(posedge core_clk);
         k++;
      end
      // A slave that never answers is a failure, not a silent skip.
      if (pready !== 1'b1) begin
         n_mismatch++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h00_0000, d}, r, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, exp);
      chk(32'(e), 32'(eexp));
   endtask
   task automatic frame(input logic [8:0] d, input logic nine, input logic stop, input realtime bt);
      u_tx.send(d, nine, stop, bt);
      repeat (40) @(posedge core_clk);
   endtask
   task automatic irq_is(input logic v);
      repeat (3) @(posedge core_clk);
      #1;
      chk(32'(receive_irq), 32'(v));
   endtask
   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic s_reset;
      rd(12'h030, 32'h00, 1'b0);
      rd(12'h060, 32'h00, 1'b0);
      rd(12'h068, 32'h00, 1'b0);
      rd(12'h230, 32'h00, 1'b0);
      rd(12'h260, 32'h02, 1'b0);
      rd(12'h264, 32'h00, 1'b0);
      rd(12'h004, 32'h00, 1'b1);
      rd(12'h061, 32'h00, 1'b1);
   endtask
   task automatic s_disabled;
      wr(12'h264, 8'h00);
      wr(12'h260, 8'h04);
      wr(12'h230, 8'h20);
      wr(12'h060, 8'h80);
      frame(9'h05A, 1'b0, 1'b1, BT);
      rd(12'h030, 32'h00, 1'b0);
      wr(12'h260, 8'h14);
      wr(12'h060, 8'h90);
      frame(9'h05B, 1'b0, 1'b1, BT);
      rd(12'h030, 32'h00, 1'b0);
      wr(12'h260, 8'h04);
   endtask
   task automatic s_basic;
      wr(12'h060, 8'h90);
      frame(9'h0A5, 1'b0, 1'b1, BT);
      irq_is(1'b1);
      rd(12'h030, 32'h20, 1'b0);
      wr(12'h230, 8'h00);
      irq_is(1'b0);
      wr(12'h230, 8'h20);
      rd(12'h060, 32'h90, 1'b0);
      rd(12'h068, 32'hA5, 1'b0);
      irq_is(1'b0);
      rd(12'h030, 32'h00, 1'b0);
   endtask
   task automatic s_overrun;
      u_tx.send(9'h011, 1'b0, 1'b1, BT);
      u_tx.send(9'h022, 1'b0, 1'b0, BT);
      frame(9'h033, 1'b0, 1'b1, BT);
      rd(12'h060, 32'h92, 1'b0);
      rd(12'h068, 32'h11, 1'b0);
      rd(12'h060, 32'h96, 1'b0);
      rd(12'h068, 32'h22, 1'b0);
      rd(12'h030, 32'h00, 1'b0);
      frame(9'h044, 1'b0, 1'b1, BT);
      rd(12'h030, 32'h00, 1'b0);
      wr(12'h060, 8'h80);
      wr(12'h060, 8'h90);
      rd(12'h060, 32'h90, 1'b0);
      frame(9'h055, 1'b0, 1'b1, BT);
      rd(12'h068, 32'h55, 1'b0);
   endtask
   task automatic s_address;
      wr(12'h060, 8'hD8);
      frame(9'h077, 1'b1, 1'b1, BT);
      frame(9'h13C, 1'b1, 1'b1, BT);
      rd(12'h060, 32'hD9, 1'b0);
      rd(12'h068, 32'h3C, 1'b0);
      rd(12'h030, 32'h00, 1'b0);
      wr(12'h060, 8'hD0);
      frame(9'h066, 1'b1, 1'b1, BT);
      rd(12'h060, 32'hD0, 1'b0);
      rd(12'h068, 32'h66, 1'b0);
   endtask
   task automatic s_sleep_slow;
      wr(12'h060, 8'h90);
      @(posedge core_clk);
      sleep_mode <= 1'b1;
      frame(9'h099, 1'b0, 1'b1, BT);
      sleep_mode <= 1'b0;
      rd(12'h030, 32'h00, 1'b0);
      wr(12'h260, 8'h00);
      frame(9'h0C3, 1'b0, 1'b1, 4.0 * BT);
      rd(12'h068, 32'hC3, 1'b0);
   endtask
   initial begin
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      s_reset();
      s_disabled();
      s_basic();
      s_overrun();
      s_address();
      s_sleep_slow();
      end_sim();
   end
   initial begin
      #100000;
      n_mismatch++;
      end_sim();
   end
endmodule
`default_nettype wire
